//--- src/slf_top.sv
// lvds output framer: slot sequencer, lane muxing, training, control
// How it works
// - full mode: 64 channels, 128-pixel bursts
// - odd rows bottom, even rows top
// - rows per frame programmable, default 3072
// - sixteen per side: row in two bursts
// - even channels disableable in sixteen mode
// - one-sided: row per burst, bottom only
// - one-sided order swaps third, fourth rows
// - one-sided: top group disableable
// - control word every slot, pixel width
// - bits 0-2: pixel, row, frame valid
// - bit 3 overhead, bits 4-5 integration
// - bit 7 one, others zero; idle 0x080
// - fewer channels lengthen valid timing
// - training word on enabled lanes without valid pixel
// - training words use the pixel width
// - primary training word at address 89
// - secondary: low byte inverted, top zero
// - secondary only the slot before row
// - row valid, pixel invalid: primary only
// - lsb first, bit 0 in high phase
// - one gap slot between bursts
`timescale 1ns/1ps
module slf_top
  import slf_pkg::*;
(
  input wire logic sys_clk, // system clock, 40 MHz
  input wire logic nrst, // async reset, active low
  input wire logic link_clk, // forwarded ddr link clock pin
  input wire logic frm_req, // frame request pin, rising edge
  input wire logic integrating_block_one_in, // block one integrating, same clock
  input wire logic integrating_block_two_in, // block two integrating, same clock
  input wire logic spi_sclk, // config serial clock pin
  input wire logic spi_cs_n, // config chip select, active low
  input wire logic spi_mosi, // config serial data in
  output logic spi_miso, // config serial data out
  output logic spi_miso_oe, // config data out enable
  input wire logic [NCH-1:0][WMAX-1:0] pix_in, // pixels for pix_req
  output slf_preq_t pix_req, // rows and position wanted
  output logic [NCH-1:0] data_out, // serial data lanes
  output logic [NCH-1:0] data_oe, // lane powered and driven
  output logic ctrl_out, // serial control lane
  output logic [1:0] status_monitor_pins // {frame_valid_flag, row_valid_flag} of the slot
);
  // every check in this module runs on sys_clk and rests during reset
  default clocking sys_cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic [15:0] rows_reg;
  logic [5:0] mode_reg;
  logic [11:0] tpw_reg;
  logic [1:0] dis_reg;
  logic wr_stb;
  logic [6:0] cfg_addr;
  logic [15:0] cfg_wdata, cfg_rdata;

  slf_spi u_spi (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi),
    .miso(spi_miso),
    .miso_oe(spi_miso_oe),
    .wr_stb(wr_stb),
    .addr(cfg_addr),
    .wdata(cfg_wdata),
    .rdata(cfg_rdata)
  );

  slf_state_t st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [5:0] bidx_reg, bidx_next;
  logic [15:0] line_reg, line_next;
  logic pend_reg, pend_next;
  logic [1:0] inte_reg;
  slf_preq_t preq_next;
  logic lk_s1;
  logic [1:0] lk_s2;
  logic [2:0] fr_s;
  logic lk_rise, lk_fall, tick, frm_rise;

  // config reads; unmapped addresses read zero
  always_comb begin
    unique case (cfg_addr)
      REG_ROWS: cfg_rdata = rows_reg;
      REG_MODE: cfg_rdata = {10'h000, mode_reg};
      REG_TPW: cfg_rdata = {4'h0, tpw_reg};
      REG_DIS: cfg_rdata = {14'h0000, dis_reg};
      REG_STAT: cfg_rdata = {pend_reg, 4'h0, st_reg, bidx_reg, 2'h0};
      default: cfg_rdata = 16'h0000;
    endcase
  end

  // config writes; a full 24-bit frame updates one register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rows_reg <= ROWS_RST;
      mode_reg <= MODE_RST;
      tpw_reg <= TPW_RST;
      dis_reg <= DIS_RST;
    end else if (wr_stb) begin
      if (cfg_addr == REG_ROWS) rows_reg <= cfg_wdata;
      if (cfg_addr == REG_MODE) mode_reg <= cfg_wdata[5:0];
      if (cfg_addr == REG_TPW) tpw_reg <= cfg_wdata[11:0];
      if (cfg_addr == REG_DIS) dis_reg <= cfg_wdata[1:0];
    end
  end

  // decoded mode; mux codes above the one-channel case clamp there
  logic [2:0] mux_m;
  logic one_side;
  logic [5:0] nb;
  logic [4:0] lane_mask;
  logic [3:0] width;
  logic tp2_sel;
  logic [11:0] tp2_w;
  slf_ctrl_t ctrl_w;
  logic [NCH:0][WMAX-1:0] words;
  logic [NCH-1:0] lane_on;

  assign mux_m = (mode_reg[2:0] > MUX_MAX) ? MUX_MAX : mode_reg[2:0];
  assign one_side = mode_reg[MODE_ONE_BIT];
  assign nb = 6'h01 << mux_m;
  assign lane_mask = 5'(nb - 6'h01);
  assign width = bits_of(mode_reg[MODE_BITS_LSB +: 2]);
  assign tp2_sel = (st_reg == ST_GAP) && (cnt_reg == 8'h00);
  assign tp2_w = tp2_of(tpw_reg);

  // control word of the slot being prepared
  always_comb begin
    ctrl_w = slf_ctrl_t'(CTRL_IDLE);
    ctrl_w.integrating_block_one = inte_reg[0];
    ctrl_w.integrating_block_two = inte_reg[1];
    ctrl_w.frame_overhead_flag = (st_reg == ST_FOT);
    ctrl_w.frame_valid_flag = (st_reg == ST_GAP) || (st_reg == ST_BURST) ||
                  (st_reg == ST_OH);
    ctrl_w.row_valid_flag = (st_reg == ST_BURST) || (st_reg == ST_OH);
    ctrl_w.pixel_valid_flag = (st_reg == ST_BURST);
  end

  // lane words: zero on disabled lanes, pixels on active lanes, training everywhere else
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      lane_on[i] = !(dis_reg[DIS_EVEN_BIT] && i[0]) &&
                   !(dis_reg[DIS_TOP_BIT] && i >= SIDE_CH);
      if (!lane_on[i]) begin
        words[i] = 12'h000;
      end else if (ctrl_w.pixel_valid_flag && (i[4:0] & lane_mask) == 5'h00 &&
                   (i < SIDE_CH || !one_side)) begin
        words[i] = pix_in[i];
      end else if (tp2_sel) begin
        words[i] = tp2_w;
      end else begin
        words[i] = tpw_reg;
      end
    end
    words[NCH] = ctrl_w;
  end

  slf_ser #(.LANES(NCH + 1), .W(WMAX)) u_ser (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .lk_rise(lk_rise),
    .lk_fall(lk_fall),
    .width(width),
    .words(words),
    .tick(tick),
    .lane_out({ctrl_out, data_out})
  );

  // link clock and frame request pass two flops before use
  assign lk_rise = lk_s2[0] & ~lk_s2[1];
  assign lk_fall = ~lk_s2[0] & lk_s2[1];
  assign frm_rise = fr_s[1] & ~fr_s[2];

  // slot sequencer, advanced once per word taken by the serializer
  logic [16:0] sent_w;
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    bidx_next = bidx_reg;
    line_next = line_reg;
    pend_next = pend_reg | frm_rise;
    sent_w = one_side ? {1'b0, line_reg} + 17'h00001 :
             {line_reg, 1'b0} + 17'h00002;
    if (tick) begin
      unique case (st_reg)
        ST_IDLE: begin
          if (pend_reg) begin
            st_next = ST_FOT;
            cnt_next = FOT_SLOTS - 8'h01;
            line_next = 16'h0000;
            pend_next = frm_rise;
          end
        end
        ST_FOT, ST_GAP: begin
          if (cnt_reg != 8'h00) begin
            cnt_next = cnt_reg - 8'h01;
          end else if (st_reg == ST_FOT) begin
            st_next = ST_GAP;
            cnt_next = GAP_SLOTS - 8'h01;
          end else begin
            st_next = ST_BURST;
            cnt_next = BURST_LAST;
            bidx_next = 6'h00;
          end
        end
        ST_BURST: begin
          if (cnt_reg != 8'h00) begin
            cnt_next = cnt_reg - 8'h01;
          end else if (bidx_reg != nb - 6'h01) begin
            st_next = ST_OH;
          end else if (sent_w >= {1'b0, rows_reg}) begin
            st_next = ST_IDLE;
          end else begin
            st_next = ST_GAP;
            cnt_next = GAP_SLOTS - 8'h01;
            line_next = line_reg + 16'h0001;
          end
        end
        ST_OH: begin
          st_next = ST_BURST;
          cnt_next = BURST_LAST;
          bidx_next = bidx_reg + 6'h01;
        end
      endcase
    end
  end

  // pixel request tracks the slot that is being prepared
  always_comb begin
    preq_next.valid = (st_next == ST_BURST);
    preq_next.burst = bidx_next;
    preq_next.pix = 7'(BURST_LAST - cnt_next);
    if (one_side) begin
      preq_next.row_bot = map_row(line_next);
      preq_next.row_top = 16'h0000;
    end else begin
      preq_next.row_bot = {line_next[14:0], 1'b1};
      preq_next.row_top = {line_next[14:0], 1'b0} + 16'h0002;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      bidx_reg <= 6'h00;
      line_reg <= 16'h0000;
      pend_reg <= 1'b0;
      inte_reg <= 2'h0;
      pix_req <= '0;
      data_oe <= '0;
      status_monitor_pins <= 2'h0;
      lk_s1 <= 1'b0;
      lk_s2 <= 2'h0;
      fr_s <= 3'h0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bidx_reg <= bidx_next;
      line_reg <= line_next;
      pend_reg <= pend_next;
      inte_reg <= {integrating_block_two_in, integrating_block_one_in};
      pix_req <= preq_next;
      data_oe <= lane_on;
      status_monitor_pins <= {ctrl_w.frame_valid_flag, ctrl_w.row_valid_flag};
      lk_s1 <= link_clk;
      lk_s2 <= {lk_s2[0], lk_s1};
      fr_s <= {fr_s[1:0], frm_req};
    end
  end

  // helper: slots of pixel-valid counted per burst
  logic [8:0] dv_cnt;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dv_cnt <= 9'h000;
    end else if (tick) begin
      dv_cnt <= ctrl_w.pixel_valid_flag ? dv_cnt + 9'h001 : 9'h000;
    end
  end

  // integration flags may change while idle, so they are masked here
  AST_IDLE_WORD: assert property (
    st_reg == ST_IDLE |->
      (ctrl_w & 12'hFCF) == CTRL_IDLE && words[0] == tpw_reg)
    else $error("idle slot lacks idle control or primary word");
  AST_TP2_FORM: assert property (
    tp2_sel |-> words[0] == {4'h0, ~tpw_reg[7:0]})
    else $error("secondary training word malformed");
  AST_TP2_BEFORE_ROW: assert property (
    tp2_sel && tick |=> ctrl_w.row_valid_flag && ctrl_w.pixel_valid_flag)
    else $error("secondary word not followed by row valid");
  AST_TP2_ONLY_ONE: assert property (
    $rose(ctrl_w.row_valid_flag) |-> $past(tp2_sel))
    else $error("row valid rose without secondary word before it");
  AST_ROW_GAP_TP1: assert property (
    ctrl_w.row_valid_flag && !ctrl_w.pixel_valid_flag |-> words[0] == tpw_reg)
    else $error("gap slot inside a row not primary word");
  AST_BURST_LEN: assert property (
    $fell(ctrl_w.pixel_valid_flag) |-> dv_cnt == BURST_PIX)
    else $error("pixel burst not 128 slots");
  AST_ONE_GAP: assert property (
    st_reg == ST_OH && tick |=> st_reg == ST_BURST)
    else $error("burst gap longer than one slot");
  AST_ROW_BURSTS: assert property (
    $fell(ctrl_w.row_valid_flag) |-> $past(bidx_reg) == nb - 6'h01)
    else $error("row ended with wrong number of bursts");
  AST_TWO_SIDE_ROWS: assert property (
    !one_side && pix_req.valid |->
      pix_req.row_bot[0] && pix_req.row_top == pix_req.row_bot + 16'h0001)
    else $error("two-sided row pairing wrong");
  // checked whether or not the top group is powered down
  AST_ONE_SIDE_TOP: assert property (
    one_side && ctrl_w.pixel_valid_flag |->
      words[SIDE_CH] == (lane_on[SIDE_CH] ? tpw_reg : 12'h000))
    else $error("top group carried pixels in one-sided mode");
  AST_FRAME_ROWS: assert property (
    $fell(ctrl_w.frame_valid_flag) |-> $past(sent_w) >= {1'b0, rows_reg})
    else $error("frame ended before all rows were sent");
endmodule

//--- src/slf_pkg.sv
// shared constants, types and helpers of the lvds output framer
package slf_pkg;
  // serial configuration register addresses
  localparam logic [6:0] REG_ROWS = 7'h01;
  localparam logic [6:0] REG_MODE = 7'h51;
  localparam logic [6:0] REG_TPW = 7'h59;
  localparam logic [6:0] REG_DIS = 7'h5C;
  localparam logic [6:0] REG_STAT = 7'h60;
  // values after reset
  localparam logic [15:0] ROWS_RST = 16'h0C00;
  localparam logic [11:0] TPW_RST = 12'h055;
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [1:0] DIS_RST = 2'h0;
  // mode and disable register fields
  localparam int MODE_MUX_LSB = 0;
  localparam int MODE_ONE_BIT = 3;
  localparam int MODE_BITS_LSB = 4;
  localparam int DIS_EVEN_BIT = 0;
  localparam int DIS_TOP_BIT = 1;
  // slot counts, sizes and fixed words
  localparam logic [7:0] BURST_LAST = 8'h7F;
  localparam logic [8:0] BURST_PIX = 9'h080;
  localparam logic [7:0] FOT_SLOTS = 8'h08;
  localparam logic [7:0] GAP_SLOTS = 8'h04;
  localparam logic [2:0] MUX_MAX = 3'h5;
  localparam int NCH = 64;
  localparam int SIDE_CH = 32;
  localparam int WMAX = 12;
  localparam logic [4:0] SPI_HDR = 5'h08;
  localparam logic [4:0] SPI_BITS = 5'h18;
  localparam logic [11:0] CTRL_IDLE = 12'h080;

  typedef struct packed {
    logic [3:0] zero_hi;
    logic marker;
    logic zero6;
    logic integrating_block_two;
    logic integrating_block_one;
    logic frame_overhead_flag;
    logic frame_valid_flag;
    logic row_valid_flag;
    logic pixel_valid_flag;
  } slf_ctrl_t;

  typedef struct packed {
    logic [15:0] row_bot;
    logic [15:0] row_top;
    logic [5:0] burst;
    logic [6:0] pix;
    logic valid;
  } slf_preq_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FOT = 3'b001,
    ST_GAP = 3'b011,
    ST_BURST = 3'b010,
    ST_OH = 3'b110
  } slf_state_t;

  // word width from the bit mode code: 0 -> 8, 1 -> 10, else 12
  function automatic logic [3:0] bits_of(input logic [1:0] m);
    bits_of = (m == 2'h0) ? 4'h8 : ((m == 2'h1) ? 4'hA : 4'hC);
  endfunction

  function automatic logic [11:0] tp2_of(input logic [11:0] tp1);
    tp2_of = {4'h0, ~tp1[7:0]};
  endfunction

  // one-sided order: third and fourth of every four swap
  function automatic logic [15:0] map_row(input logic [15:0] n);
    map_row = {n[15:1], n[0] ^ n[1]} + 16'h0001;
  endfunction
endpackage

//--- src/slf_spi.sv
// serial configuration port slave, mode 0, msb first
`timescale 1ns/1ps
module slf_spi
  import slf_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic sclk, // serial clock pin
  input wire logic cs_n, // chip select pin, active low
  input wire logic mosi, // serial data in pin
  output logic miso, // serial data out
  output logic miso_oe, // data out enable
  output logic wr_stb, // one-cycle write strobe
  output logic [6:0] addr, // register address of the frame
  output logic [15:0] wdata, // write data
  input wire logic [15:0] rdata // read data for addr
);
  logic [2:0] s1_reg, s2_reg, s2_next;
  logic s3_reg;
  logic [4:0] cnt_reg, cnt_next;
  logic [23:0] sh_reg, sh_next;
  logic [15:0] osh_reg, osh_next;
  logic [6:0] addr_next;
  logic wr_next, miso_next, oe_next;
  logic rise, fall;

  // pins pass two flops; edges only from the second stage
  assign s2_next = s1_reg;
  assign rise = s2_reg[2] & ~s3_reg;
  assign fall = ~s2_reg[2] & s3_reg;

  // shift, decode header, load read data one edge later
  always_comb begin
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    osh_next = osh_reg;
    addr_next = addr;
    wr_next = 1'b0;
    miso_next = miso;
    oe_next = ~s2_reg[1];
    if (s2_reg[1]) begin
      cnt_next = 5'h00;
    end else if (rise) begin
      sh_next = {sh_reg[22:0], s2_reg[0]};
      cnt_next = cnt_reg + 5'h01;
      if (cnt_next == SPI_HDR) begin
        addr_next = sh_next[6:0];
      end
      if (cnt_next == SPI_BITS && sh_next[23]) begin
        wr_next = 1'b1;
      end
    end else if (fall && cnt_reg >= SPI_HDR) begin
      if (cnt_reg == SPI_HDR) begin
        miso_next = rdata[15];
        osh_next = {rdata[14:0], 1'b0};
      end else begin
        miso_next = osh_reg[15];
        osh_next = {osh_reg[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 3'h2;
      s2_reg <= 3'h2;
      s3_reg <= 1'b0;
      cnt_reg <= 5'h00;
      sh_reg <= 24'h000000;
      osh_reg <= 16'h0000;
      addr <= 7'h00;
      wr_stb <= 1'b0;
      wdata <= 16'h0000;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      s1_reg <= {sclk, cs_n, mosi};
      s2_reg <= s2_next;
      s3_reg <= s2_reg[2];
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      osh_reg <= osh_next;
      addr <= addr_next;
      wr_stb <= wr_next;
      wdata <= sh_next[15:0];
      miso <= miso_next;
      miso_oe <= oe_next;
    end
  end
endmodule

//--- src/slf_ser.sv
// shared-counter serializer for all data lanes and the control lane
`timescale 1ns/1ps
module slf_ser
  import slf_pkg::*;
#(
  parameter int LANES = 65,
  parameter int W = 12
)(
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic lk_rise, // link clock rising edge seen
  input wire logic lk_fall, // link clock falling edge seen
  input wire logic [3:0] width, // bits per word
  input wire logic [LANES-1:0][W-1:0] words, // next word per lane
  output logic tick, // pulse: words taken
  output logic [LANES-1:0] lane_out // serial bit per lane
);
  logic [3:0] bit_reg, bit_next;
  logic [LANES-1:0][W-1:0] sh_reg, sh_next;
  logic [LANES-1:0] out_next;
  logic tick_next;

  // word starts on a rising edge: even widths keep bit 0 high-phase
  always_comb begin
    bit_next = bit_reg;
    sh_next = sh_reg;
    out_next = lane_out;
    tick_next = 1'b0;
    if (lk_rise && bit_reg == 4'h0) begin
      tick_next = 1'b1;
      bit_next = 4'h1;
      for (int i = 0; i < LANES; i++) begin
        out_next[i] = words[i][0];
        sh_next[i] = words[i] >> 1;
      end
    end else if ((lk_rise || lk_fall) && bit_reg != 4'h0) begin
      bit_next = (bit_reg == width - 4'h1) ? 4'h0 : bit_reg + 4'h1;
      for (int i = 0; i < LANES; i++) begin
        out_next[i] = sh_reg[i][0];
        sh_next[i] = sh_reg[i] >> 1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bit_reg <= 4'h0;
      sh_reg <= '0;
      lane_out <= '0;
      tick <= 1'b0;
    end else begin
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      lane_out <= out_next;
      tick <= tick_next;
    end
  end

  AST_LSB_FIRST: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    tick |-> lane_out[0] == $past(words[0][0]) && $past(lk_rise))
    else $error("word did not start with bit 0 on a rising edge");
endmodule

//--- verification/slf_rx_model.sv
// receiver model: deserializes every lane on the forwarded link clock
`timescale 1ns/1ps
module slf_rx_model
  import slf_pkg::*;
(
  input wire logic link_clk, // forwarded ddr link clock
  input wire logic [NCH-1:0] data_out, // serial data lanes
  input wire logic ctrl_out, // serial control lane
  input wire logic [3:0] width, // bits per word now in use
  input wire logic relock, // level: drop word alignment
  output logic word_stb, // short pulse: a new set of words
  output logic [11:0] ctrl_word, // last control word
  output logic [NCH-1:0][11:0] lane_word // last data words
);
  logic [NCH:0][11:0] sh = '0;
  logic locked = 1'b0;
  int cnt = 0;
  initial begin
    word_stb = 1'b0;
    ctrl_word = '0;
    lane_word = '0;
  end
  // sample 80 ns after both edges, just after the launch each edge causes; lsb comes first
  always @(link_clk) begin
    #80;
    for (int i = 0; i < NCH; i++) begin
      sh[i] = {data_out[i], sh[i][11:1]};
    end
    sh[NCH] = {ctrl_out, sh[NCH][11:1]};
    cnt = cnt + 1;
    if (relock) begin
      locked = 1'b0;
    end else if (!locked && (sh[NCH] >> (12 - width)) == CTRL_IDLE) begin
      // word edges only found on the idle control word
      locked = 1'b1;
      cnt = 0;
    end else if (locked && cnt == width) begin
      cnt = 0;
      ctrl_word = sh[NCH] >> (12 - width);
      for (int i = 0; i < NCH; i++) begin
        lane_word[i] = sh[i] >> (12 - width);
      end
      word_stb = 1'b1;
      #10;
      word_stb = 1'b0;
    end
  end
endmodule

//--- verification/slf_top_tb.sv
// self-checking bench for the lvds output framer
`timescale 1ns/1ps
module slf_top_tb
  import slf_pkg::*;
();
  logic sys_clk = 1'b0, nrst = 1'b0, link_clk = 1'b0, frm_req = 1'b0;
  logic integrating_block_one_in = 1'b0, integrating_block_two_in = 1'b0, spi_sclk = 1'b0;
  logic spi_cs_n = 1'b1, spi_mosi = 1'b0, relock = 1'b0;
  logic spi_miso, spi_miso_oe, word_stb, ctrl_out;
  logic [NCH-1:0][WMAX-1:0] pix_in;
  slf_preq_t pix_req;
  logic [NCH-1:0] data_out, data_oe;
  logic [1:0] mon;
  logic [3:0] cur_w = 4'h8;
  logic [11:0] ctrl_word;
  logic [NCH-1:0][11:0] lane_word;
  typedef struct packed {
    logic [11:0] c;
    logic [NCH-1:0][11:0] d;
  } slf_wrd_t;
  slf_wrd_t q[$];
  logic cap = 1'b0, seen_f = 1'b0, done = 1'b0;
  int error_cnt = 0, checks = 0, cyc = 0;

  always #12.5 sys_clk = ~sys_clk;
  // link clock free-running, phase unrelated to the system clock
  initial begin
    #37;
    forever #100 link_clk = ~link_clk;
  end
  // pixel words name row and position, so misrouting shows up
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pix_in[i] = {pix_req.pix, pix_req.burst[0],
                   (i < 32) ? pix_req.row_bot[3:0] : pix_req.row_top[3:0]};
    end
  end

  slf_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .link_clk(link_clk),
    .frm_req(frm_req), .integrating_block_one_in(integrating_block_one_in), .integrating_block_two_in(integrating_block_two_in),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .pix_in(pix_in),
    .pix_req(pix_req), .data_out(data_out), .data_oe(data_oe),
    .ctrl_out(ctrl_out), .status_monitor_pins(mon));
  slf_rx_model rx_u (.link_clk(link_clk), .data_out(data_out),
    .ctrl_out(ctrl_out), .width(cur_w), .relock(relock),
    .word_stb(word_stb), .ctrl_word(ctrl_word), .lane_word(lane_word));

  // record words of a frame; done once the frame valid flag went away
  always @(posedge word_stb) begin
    if (cap) begin
      q.push_back(slf_wrd_t'({ctrl_word, lane_word}));
      if (ctrl_word[2]) seen_f = 1'b1;
      if (seen_f && ctrl_word[3:2] == 2'h0) done = 1'b1;
    end
  end
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      error_cnt = error_cnt + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    checks = checks + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one 24-bit config frame; sclk phases kept four clocks long, above three
  task automatic spi(input logic [23:0] f, output logic [15:0] rd);
    rd = '0;
    spi_cs_n = 1'b0;
    for (int b = 23; b >= 0; b--) begin
      spi_mosi = f[b];
      tick(4);
      spi_sclk = 1'b1;
      if (b == 15) chk("miso enable", 1, spi_miso_oe);
      if (b < 16) rd[b] = spi_miso;
      tick(4);
      spi_sclk = 1'b0;
    end
    tick(4);
    spi_cs_n = 1'b1;
    tick(6);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] rd;
    spi({1'b1, a, d}, rd);
  endtask
  // width changes move word edges, so the receiver aligns again
  task automatic resync(input logic [3:0] w);
    cur_w = w;
    tick(60);
    relock = 1'b1;
    tick(12);
    relock = 1'b0;
    tick(150);
  endtask
  task automatic run_frame();
    bit mon_l = 1'b0;
    q.delete();
    seen_f = 1'b0;
    done = 1'b0;
    cap = 1'b1;
    frm_req = 1'b1;
    tick(4);
    frm_req = 1'b0;
    for (int n = 0; n < 40000 && !done; n++) begin
      tick(1);
      mon_l = mon_l | (mon == 2'h3);
    end
    cap = 1'b0;
    chk("frame done", 1, done);
    chk("monitor in row", 1, mon_l);
  endtask
  function automatic int rowf(input int l);
    int t;
    t = l % 4;
    rowf = 4 * (l / 4) + ((t == 2) ? 4 : (t == 3) ? 3 : t + 1);
  endfunction
  // walk the captured words; the receiver only trusts the three valids
  task automatic analyze(input int mux, input bit one, input logic [11:0] tp,
                         input int rows, input logic [1:0] dis);
    logic [11:0] c, e, wm;
    logic [63:0] m;
    int k = 0, b = 0, gap = 0, ln = 0, r;
    bit frame_overhead_flag = 1'b0, en, act;
    wm = (12'h001 << cur_w) - 12'h001;
    for (int j = 0; j + 1 < q.size(); j++) begin
      c = q[j].c;
      chk("ctrl fixed", 12'h080 & wm, c & 12'hFC0 & wm);
      frame_overhead_flag = frame_overhead_flag | c[3];
      if (c[2]) chk("overhead first", 1, frame_overhead_flag);
      if (c[0]) begin
        chk("valid nest", 3'h7, c[2:0]);
        if (k == 0 && b > 0) chk("burst gap", 1, gap);
        gap = 0;
      end else if (c[1]) begin
        gap = gap + 1;
      end
      r = one ? rowf(ln) : 2 * ln + 1;
      for (int i = 0; i < NCH; i++) begin
        en = !(dis[0] && i[0]) && !(dis[1] && i >= 32);
        act = en && ((i % 32) % (1 << mux) == 0) && (!one || i < 32);
        m[i] = en;
        if (!en) e = '0;
        else if (c[0] && act) e = {k[6:0], b[0], 4'(r + (i >= 32))};
        else if (!c[1] && q[j + 1].c[1]) e = {4'h0, ~tp[7:0]};
        else e = tp;
        chk("lane word", e & wm, q[j].d[i]);
      end
      if (c[0]) begin
        k = k + 1;
        if (k == 128) begin
          k = 0;
          b = b + 1;
        end
      end
      if (c[1] && !q[j + 1].c[1]) begin
        chk("bursts per row", 1 << mux, b);
        b = 0;
        ln = ln + 1;
      end
    end
    chk("rows", rows, ln * (one ? 1 : 2));
    chk("lane enables", m, data_oe);
  endtask

  task automatic t_idle();
    logic [15:0] rd;
    spi({1'b0, REG_TPW, 16'h0000}, rd);
    chk("tp reset", TPW_RST, rd);
    spi({1'b0, REG_ROWS, 16'h0000}, rd);
    chk("rows reset", ROWS_RST, rd);
    spi({1'b0, 7'h5D, 16'h0000}, rd);
    chk("unmapped", 0, rd);
    tick(100);
    chk("idle ctrl", CTRL_IDLE, ctrl_word);
    chk("idle lane", TPW_RST & 12'h0FF, lane_word[5]);
    chk("oe reset", {NCH{1'b1}}, data_oe);
    chk("monitor idle", 0, mon);
    chk("miso idle off", 0, spi_miso_oe);
    integrating_block_one_in = 1'b1;
    tick(80);
    chk("block one", 12'h090, ctrl_word);
    integrating_block_one_in = 1'b0;
    integrating_block_two_in = 1'b1;
    tick(80);
    chk("block two", 12'h0A0, ctrl_word);
    integrating_block_two_in = 1'b0;
  endtask
  task automatic t_full();
    logic [15:0] rd;
    wr(REG_ROWS, 16'h0004);
    wr(REG_TPW, 16'h0A5C);
    spi({1'b0, REG_TPW, 16'h0000}, rd);
    chk("tp readback", 12'hA5C, rd);
    tick(100);
    run_frame();
    analyze(0, 1'b0, 12'hA5C, 4, 2'h0);
  endtask
  task automatic t_mux();
    logic [15:0] rd;
    wr(REG_ROWS, 16'h0002);
    wr(REG_MODE, 16'h0011);
    wr(REG_DIS, 16'h0001);
    resync(4'hA);
    run_frame();
    analyze(1, 1'b0, 12'hA5C, 2, 2'h1);
    spi({1'b0, REG_STAT, 16'h0000}, rd);
    chk("status after frame", 16'h0004, rd);
  endtask
  task automatic t_one();
    wr(REG_ROWS, 16'h0004);
    wr(REG_MODE, 16'h0028);
    wr(REG_DIS, 16'h0002);
    resync(4'hC);
    run_frame();
    analyze(0, 1'b1, 12'hA5C, 4, 2'h2);
  endtask

  initial begin
    tick(4);
    nrst = 1'b1;
    tick(8);
    t_idle();
    t_full();
    t_mux();
    t_one();
    give_verdict();
  end
endmodule
